// file: design/sync_regs_map.svh
/*
 * register offsets, field positions, reset values and bus constants
 * for the sync control and status bank.
 * assumes inclusion by bare name from the design file.
 */
`ifndef SYNC_REGS_MAP_SVH
`define SYNC_REGS_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_SLICER_CLAMP 8'h10
`define OFS_SEP_THRESH 8'h11
`define OFS_LEAD_LINES 8'h12
`define OFS_TRAIL_LINES 8'h13
`define OFS_STATUS 8'h14
`define OFS_LAST 8'h14

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_SLICER_CLAMP 8'hB8
`define RST_SEP_THRESH 8'h20
`define RST_LEAD_LINES 8'h00
`define RST_TRAIL_LINES 8'h00
`define RST_POINTER 8'h00

// ----------------------------------------------------------------
// fields of the slicer and clamp register
// ----------------------------------------------------------------
`define SLICER_HI 7
`define SLICER_LO 3
`define CLAMP_HI 2
`define CLAMP_LO 0

// ----------------------------------------------------------------
// serial port constants
// ----------------------------------------------------------------
`define DEV_ADDR_HIGH 5'h13
`define BITS_DATA 4'h8
`define BITS_ACK 4'h9
`define BITS_ZERO 4'h0

`endif

// file: design/sync_regs_pkg.sv
/*
 * types shared by the sync control and status bank.
 * assumes nothing of its surroundings.
 */
package sync_regs_pkg;

    // serial port phase
    typedef enum logic [2:0] {
        SER_IDLE,
        SER_DEV_ADDR,
        SER_REG_ADDR,
        SER_WRITE,
        SER_READ
    } serial_state_type;

endpackage

// file: design/sync_control_status_regs.sv
/*
 * control and status registers 10h..14h of the video front end,
 * reached over the two-wire serial slave port, plus holdover timing.
 * assumes scl, sda, address selects and sync inputs are asynchronous
 * pins; source override and select bits come from core-clock logic.
 */
`include "sync_regs_map.svh"

module sync_control_status_regs #(
    parameter int LINE_W = 12
) (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    // serial port pins
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA,
    output logic O_SDA_OE,
    input wire logic [1:0] I_ADDRESS_SELECT_PINS,
    // detector levels from the sync processing block
    input wire logic I_HSYNC_ACTIVE,
    input wire logic I_HSYNC_POL,
    input wire logic I_VSYNC_ACTIVE,
    input wire logic I_VSYNC_POL,
    input wire logic I_GREEN_EMBEDDED_SYNC_ACTIVE,
    input wire logic I_HOLDOVER_POL,
    // source selection from mode control
    input wire logic I_HSRC_OVERRIDE,
    input wire logic I_HSRC_SELECT,
    input wire logic I_VSRC_OVERRIDE,
    input wire logic I_VSRC_SELECT,
    // selected sync for holdover timing, active high
    input wire logic I_HSYNC,
    input wire logic I_VSYNC,
    // control outputs
    output logic [4:0] O_SLICER_THRESHOLD,
    output logic [2:0] O_CLAMP_MIDSCALE,
    output logic [7:0] O_SEPARATOR_THRESHOLD,
    output logic [7:0] O_HOLDOVER_LEAD,
    output logic [7:0] O_HOLDOVER_TRAIL,
    output logic O_HORIZONTAL_SOURCE_IN_USE,
    output logic O_VERTICAL_SOURCE_IN_USE,
    output logic O_HOLDOVER
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    // the line counter must be wider than the 8-bit lead count
    if (LINE_W < 9 || LINE_W > 16) begin : bad_width
        $error("LINE_W must lie between 9 and 16");
    end

    // saturating pointer step, used on reads and writes
    function automatic logic [7:0] step_pointer(input logic [7:0] p);
        return (p >= `OFS_LAST) ? `OFS_LAST : 8'(p + 8'h01);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // 12 async levels: scl, sda, 2 selects, 6 detectors, hs, vs
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] pin_meta; // first stage, read only by second
    logic [NSYNC-1:0] pin_sync; // second stage, safe to use
    logic scl_prev; // previous synchronised scl
    logic sda_prev; // previous synchronised sda
    logic hs_prev; // previous synchronised hsync
    logic vs_prev; // previous synchronised vsync
    wire [NSYNC-1:0] pin_raw = {I_VSYNC, I_HSYNC, I_HOLDOVER_POL,
        I_GREEN_EMBEDDED_SYNC_ACTIVE, I_VSYNC_POL, I_VSYNC_ACTIVE,
        I_HSYNC_POL, I_HSYNC_ACTIVE, I_ADDRESS_SELECT_PINS, I_SDA, I_SCL};

    // two-stage capture of every asynchronous pin
    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            pin_meta <= '1;
            pin_sync <= '1;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // named views of the synchronised pins
    wire scl = pin_sync[0];
    wire sda = pin_sync[1];
    wire [1:0] addr_sel = pin_sync[3:2];
    wire hs_active = pin_sync[4];
    wire hs_pol = pin_sync[5];
    wire vs_active = pin_sync[6];
    wire vs_pol = pin_sync[7];
    wire ges_active = pin_sync[8];
    wire hold_pol = pin_sync[9];
    wire hs_in = pin_sync[10];
    wire vs_in = pin_sync[11];

    // edge history, reset high like an idle bus
    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            hs_prev <= 1'b1;
            vs_prev <= 1'b1;
        end else begin
            scl_prev <= scl;
            sda_prev <= sda;
            hs_prev <= hs_in;
            vs_prev <= vs_in;
        end
    end

    // ------------------------------------------------------------
    // bus events
    // ------------------------------------------------------------
    wire scl_rise = scl & ~scl_prev;
    wire scl_fall = ~scl & scl_prev;
    wire bus_start = scl & scl_prev & sda_prev & ~sda;
    wire bus_stop = scl & scl_prev & ~sda_prev & sda;

    // ------------------------------------------------------------
    // registers and serial state
    // ------------------------------------------------------------
    sync_regs_pkg::serial_state_type state; // serial phase
    logic [3:0] bit_cnt; // scl rises within the byte
    logic [7:0] shreg; // shift register
    logic [7:0] pointer; // register pointer
    logic read_dir; // direction bit latched
    logic acked; // last byte was acknowledged
    logic [7:0] reg_slicer; // offset 10h
    logic [7:0] reg_sep; // offset 11h
    logic [7:0] reg_lead; // offset 12h
    logic [7:0] reg_trail; // offset 13h
    logic [7:0] reg_status; // offset 14h, sampled state

    wire addr_match = (shreg[7:1] == {`DEV_ADDR_HIGH, addr_sel});
    wire base_ok = (shreg <= `OFS_LAST);
    wire ack_now = (state == sync_regs_pkg::SER_DEV_ADDR) ? addr_match
                 : (state == sync_regs_pkg::SER_REG_ADDR) ? base_ok
                 : (state == sync_regs_pkg::SER_WRITE);
    wire write_strobe = scl_fall && bit_cnt == `BITS_DATA
                      && state == sync_regs_pkg::SER_WRITE;

    // read data selection; unmapped offsets below 10h read zero
    wire [7:0] read_data =
          (pointer == `OFS_SLICER_CLAMP) ? reg_slicer
        : (pointer == `OFS_SEP_THRESH) ? reg_sep
        : (pointer == `OFS_LEAD_LINES) ? reg_lead
        : (pointer == `OFS_TRAIL_LINES) ? reg_trail
        : (pointer == `OFS_STATUS) ? reg_status
        : 8'h00;

    // ------------------------------------------------------------
    // serial protocol engine
    // ------------------------------------------------------------
    // bits are sampled on scl rise and driven after scl fall
    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state <= sync_regs_pkg::SER_IDLE;
            bit_cnt <= `BITS_ZERO;
            shreg <= 8'h00;
            pointer <= `RST_POINTER;
            read_dir <= 1'b0;
            acked <= 1'b0;
            O_SDA_OE <= 1'b0;
        end else if (bus_start) begin
            state <= sync_regs_pkg::SER_DEV_ADDR;
            bit_cnt <= `BITS_ZERO;
            O_SDA_OE <= 1'b0;
        end else if (bus_stop) begin
            state <= sync_regs_pkg::SER_IDLE;
            O_SDA_OE <= 1'b0;
        end else if (state != sync_regs_pkg::SER_IDLE) begin
            if (scl_rise) begin
                bit_cnt <= 4'(bit_cnt + 4'h1);
                if (bit_cnt < `BITS_DATA && state != sync_regs_pkg::SER_READ) begin
                    shreg <= {shreg[6:0], sda};
                end
                // master nack ends a read
                if (bit_cnt == `BITS_DATA && state == sync_regs_pkg::SER_READ && sda) begin
                    state <= sync_regs_pkg::SER_IDLE;
                end
            end else if (scl_fall) begin
                if (bit_cnt == `BITS_DATA) begin
                    if (state == sync_regs_pkg::SER_READ) begin
                        // release for the master's acknowledge
                        O_SDA_OE <= 1'b0;
                        pointer <= step_pointer(pointer);
                    end else begin
                        O_SDA_OE <= ack_now;
                        acked <= ack_now;
                        if (state == sync_regs_pkg::SER_DEV_ADDR) begin
                            read_dir <= shreg[0];
                        end
                        if (state == sync_regs_pkg::SER_REG_ADDR && base_ok) begin
                            pointer <= shreg;
                        end
                        if (state == sync_regs_pkg::SER_WRITE) begin
                            pointer <= step_pointer(pointer);
                        end
                    end
                end else if (bit_cnt == `BITS_ACK) begin
                    bit_cnt <= `BITS_ZERO;
                    O_SDA_OE <= 1'b0;
                    if (!acked && state != sync_regs_pkg::SER_READ) begin
                        // refused byte: stay off the bus until the next start
                        state <= sync_regs_pkg::SER_IDLE;
                    end else if (state == sync_regs_pkg::SER_DEV_ADDR) begin
                        state <= read_dir ? sync_regs_pkg::SER_READ
                                          : sync_regs_pkg::SER_REG_ADDR;
                        if (read_dir) begin
                            shreg <= read_data;
                            O_SDA_OE <= ~read_data[7];
                        end
                    end else if (state == sync_regs_pkg::SER_REG_ADDR) begin
                        state <= sync_regs_pkg::SER_WRITE;
                    end else if (state == sync_regs_pkg::SER_READ) begin
                        // next byte after master ack
                        shreg <= read_data;
                        O_SDA_OE <= ~read_data[7];
                    end
                end else if (state == sync_regs_pkg::SER_READ) begin
                    shreg <= {shreg[6:0], 1'b0};
                    O_SDA_OE <= ~shreg[6];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            reg_slicer <= `RST_SLICER_CLAMP;
            reg_sep <= `RST_SEP_THRESH;
            reg_lead <= `RST_LEAD_LINES;
            reg_trail <= `RST_TRAIL_LINES;
        end else if (write_strobe) begin
            if (pointer == `OFS_SLICER_CLAMP) reg_slicer <= shreg;
            if (pointer == `OFS_SEP_THRESH) reg_sep <= shreg;
            if (pointer == `OFS_LEAD_LINES) reg_lead <= shreg;
            if (pointer == `OFS_TRAIL_LINES) reg_trail <= shreg;
        end
    end

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    // horizontal source in use
    wire hsrc_auto = hs_active ^ ges_active;
    wire next_hsrc = (I_HSRC_OVERRIDE || !hsrc_auto) ? I_HSRC_SELECT : ges_active;
    wire next_vsrc = I_VSRC_OVERRIDE ? I_VSRC_SELECT : vs_active;

    // sampled every cycle so reads show live state
    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            reg_status <= 8'h00;
        end else begin
            reg_status <= {hs_active, next_hsrc, hs_pol, vs_active,
                           next_vsrc, vs_pol, ges_active, hold_pol};
        end
    end

    // ------------------------------------------------------------
    // holdover timing
    // ------------------------------------------------------------
    logic [LINE_W-1:0] line_cnt; // hsync edges since vsync start
    logic [LINE_W-1:0] frame_len; // lines of the last frame
    logic [7:0] trail_left; // lines of trailing holdover left
    wire hs_edge = hs_in & ~hs_prev;
    wire vs_start = vs_in & ~vs_prev;
    wire vs_end = ~vs_in & vs_prev;
    wire [LINE_W:0] lead_reach = {1'b0, line_cnt} + (LINE_W+1)'(reg_lead);
    wire in_lead = (reg_lead != 8'h00) && (frame_len != '0)
                 && (lead_reach >= {1'b0, frame_len});

    // counts lines; the lead window relies on a steady frame length
    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            line_cnt <= '0;
            frame_len <= '0;
            trail_left <= 8'h00;
        end else begin
            if (vs_start) begin
                frame_len <= line_cnt;
                line_cnt <= '0;
            end else if (hs_edge && line_cnt != '1) begin
                line_cnt <= LINE_W'(line_cnt + 1'b1);
            end
            if (vs_end) begin
                trail_left <= reg_trail;
            end else if (hs_edge && !vs_in && trail_left != 8'h00) begin
                trail_left <= 8'(trail_left - 8'h01);
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_SDA <= 1'b0;
            O_SLICER_THRESHOLD <= 5'h00;
            O_CLAMP_MIDSCALE <= 3'h0;
            O_SEPARATOR_THRESHOLD <= 8'h00;
            O_HOLDOVER_LEAD <= 8'h00;
            O_HOLDOVER_TRAIL <= 8'h00;
            O_HORIZONTAL_SOURCE_IN_USE <= 1'b0;
            O_VERTICAL_SOURCE_IN_USE <= 1'b0;
            O_HOLDOVER <= 1'b0;
        end else begin
            // open drain: data always low, enable does the work
            O_SDA <= 1'b0;
            O_SLICER_THRESHOLD <= reg_slicer[`SLICER_HI:`SLICER_LO];
            O_CLAMP_MIDSCALE <= reg_slicer[`CLAMP_HI:`CLAMP_LO];
            O_SEPARATOR_THRESHOLD <= reg_sep;
            O_HOLDOVER_LEAD <= reg_lead;
            O_HOLDOVER_TRAIL <= reg_trail;
            O_HORIZONTAL_SOURCE_IN_USE <= next_hsrc;
            O_VERTICAL_SOURCE_IN_USE <= next_vsrc;
            O_HOLDOVER <= vs_in | in_lead | (trail_left != 8'h00);
        end
    end

endmodule

// file: sim/sync_regs_check_monitor.sv
/*
 * concurrent checks on the sync control and status bank pins.
 * assumes binding onto the design top; one core clock domain.
 */
module sync_regs_check (
    // clock and reset
    input logic I_CORE_CLK,
    input logic I_SYS_RST,
    // serial pins
    input logic I_SCL,
    input logic I_SDA,
    input logic O_SDA,
    input logic O_SDA_OE,
    // detector levels and source controls
    input logic I_HSYNC_ACTIVE,
    input logic I_GREEN_EMBEDDED_SYNC_ACTIVE,
    input logic I_HSRC_OVERRIDE,
    input logic I_HSRC_SELECT,
    input logic I_VSYNC_ACTIVE,
    input logic I_VSRC_OVERRIDE,
    input logic I_VSRC_SELECT,
    input logic I_VSYNC,
    // control outputs
    input logic [4:0] O_SLICER_THRESHOLD,
    input logic [2:0] O_CLAMP_MIDSCALE,
    input logic [7:0] O_SEPARATOR_THRESHOLD,
    input logic [7:0] O_HOLDOVER_LEAD,
    input logic [7:0] O_HOLDOVER_TRAIL,
    input logic O_HORIZONTAL_SOURCE_IN_USE,
    input logic O_VERTICAL_SOURCE_IN_USE,
    input logic O_HOLDOVER
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SYS_RST);
    // cycles since reset; hides the load of reset values
    logic [3:0] age;
    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            age <= 4'h0;
        end else if (age != 4'hF) begin
            age <= age + 4'h1;
        end
    end
    // ------------------------------
    // assertions
    // ------------------------------
    rst_ctrl_a: assert property ($fell(I_SYS_RST) |=>
        O_SLICER_THRESHOLD == 5'h17 && O_CLAMP_MIDSCALE == 3'h0)
        else $error("slicer or clamp reset value wrong");
    rst_count_a: assert property ($fell(I_SYS_RST) |=>
        O_SEPARATOR_THRESHOLD == 8'h20 && {O_HOLDOVER_LEAD, O_HOLDOVER_TRAIL} == 16'h0000)
        else $error("count register reset value wrong");
    ctrl_quiet_a: assert property (age == 4'hF && !$stable({O_SLICER_THRESHOLD,
        O_CLAMP_MIDSCALE, O_SEPARATOR_THRESHOLD, O_HOLDOVER_LEAD, O_HOLDOVER_TRAIL}) |->
        $past(I_SCL, 5) && !$past(I_SCL, 4))
        else $error("control output moved away from the scl fall");
    sda_od_a: assert property (O_SDA_OE |-> O_SDA == 1'b0)
        else $error("data pin driven high");
    sda_edge_a: assert property ($changed(O_SDA_OE) |-> !I_SCL)
        else $error("slave moved sda while scl high");
    stop_idle_a: assert property ($rose(I_SDA) && I_SCL |=> !O_SDA_OE [*8])
        else $error("slave drove sda after stop");
    hsrc_a: assert property ($stable({I_HSRC_OVERRIDE, I_HSRC_SELECT,
        I_HSYNC_ACTIVE, I_GREEN_EMBEDDED_SYNC_ACTIVE}) [*8] |-> O_HORIZONTAL_SOURCE_IN_USE ==
        ((!I_HSRC_OVERRIDE && (I_HSYNC_ACTIVE ^ I_GREEN_EMBEDDED_SYNC_ACTIVE)) ?
        I_GREEN_EMBEDDED_SYNC_ACTIVE : I_HSRC_SELECT))
        else $error("horizontal source wrong");
    vsrc_a: assert property ($stable({I_VSRC_OVERRIDE, I_VSRC_SELECT, I_VSYNC_ACTIVE}) [*8]
        |-> O_VERTICAL_SOURCE_IN_USE == (I_VSRC_OVERRIDE ? I_VSRC_SELECT : I_VSYNC_ACTIVE))
        else $error("vertical source wrong");
    hold_vsync_a: assert property (I_VSYNC [*8] |-> O_HOLDOVER)
        else $error("holdover low during vsync");
    // ------------------------------
    // covers
    // ------------------------------
    wr_seen_c: cover property (age == 4'hF && $changed(O_SEPARATOR_THRESHOLD));
    ack_seen_c: cover property ($rose(O_SDA_OE));
    hold_end_c: cover property ($fell(O_HOLDOVER));
endmodule

bind sync_control_status_regs sync_regs_check chk (.*);

// file: sim/twowire_master_model.sv
/*
 * two-wire bus master model for the serial port of the sync bank.
 * assumes a pull-up on sda outside; scl stands high between frames.
 */
module twowire_master_model (
    // bench clock
    input wire logic clk,
    // bus lines; sda_pull high pulls sda low
    input wire logic sda_in,
    output logic scl,
    output logic sda_pull,
    // results handed to the bench
    output logic res_valid,
    output logic [7:0] res_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // scl phase in clocks, 32 ns period; slave answers 3 clocks after a fall
    localparam int PH = 4;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        res_valid = 1'b0;
        res_data = 8'h00;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic report(input logic [7:0] v);
        res_data <= v;
        res_valid <= 1'b1;
        wait_cyc(1);
        res_valid <= 1'b0;
    endtask
    task automatic start_cond();
        sda_pull <= 1'b0;
        wait_cyc(PH / 2);
        scl <= 1'b1;
        wait_cyc(PH);
        sda_pull <= 1'b1;
        wait_cyc(PH);
        scl <= 1'b0;
        wait_cyc(PH / 2);
    endtask
    task automatic bit_xfer(input logic b, output logic r);
        sda_pull <= ~b;
        wait_cyc(PH / 2);
        scl <= 1'b1;
        wait_cyc(PH);
        r = sda_in;
        scl <= 1'b0;
        wait_cyc(PH / 2);
    endtask
    // msb first, ack reported as 1
    task automatic put_byte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, r);
        report({7'h00, ~r});
    endtask
    // msb first; last byte is not acknowledged
    task automatic get_byte(input logic last);
        logic [7:0] d;
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(last, r);
        report(d);
    endtask
    task automatic stop_cond();
        sda_pull <= 1'b1;
        wait_cyc(PH / 2);
        scl <= 1'b1;
        wait_cyc(PH);
        sda_pull <= 1'b0;
        wait_cyc(PH);
    endtask
endmodule

// file: sim/sync_control_status_regs_tb_top.sv
/*
 * self-checking bench for the sync control and status bank.
 * assumes design, checker and master model are compiled first.
 */
`include "sync_regs_map.svh"
module sync_control_status_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string nm; logic [7:0] v;} note_type;
    // ------------------------------
    // pins and bench state
    // ------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] sa = 2'h0;
    // detector levels then source override and select bits
    logic [9:0] st = 10'h000;
    logic hsync = 1'b0;
    logic vsync = 1'b0;
    logic scl, m_pull, o_sda, sda_oe, res_valid, hsrc, vsrc, hold;
    logic [7:0] res_data, sep, lead, trail, rnd;
    logic [4:0] slicer;
    logic [2:0] clamp;
    // pull-up: a released line reads high
    wire sda = ~(m_pull | sda_oe);
    note_type exp_q[$];
    logic [7:0] mirror [5] = '{8'hB8, 8'h20, 8'h00, 8'h00, 8'h00};
    int fail_count = 0;
    int n_tests = 0;
    int seed = 15;
    always #2 clk = ~clk;
    sync_control_status_regs uut (
        .I_CORE_CLK(clk),
        .I_SYS_RST(rst),
        .I_SCL(scl),
        .I_SDA(sda),
        .O_SDA(o_sda),
        .O_SDA_OE(sda_oe),
        .I_ADDRESS_SELECT_PINS(sa),
        .I_HSYNC_ACTIVE(st[9]),
        .I_HSYNC_POL(st[8]),
        .I_VSYNC_ACTIVE(st[7]),
        .I_VSYNC_POL(st[6]),
        .I_GREEN_EMBEDDED_SYNC_ACTIVE(st[5]),
        .I_HOLDOVER_POL(st[4]),
        .I_HSRC_OVERRIDE(st[3]),
        .I_HSRC_SELECT(st[2]),
        .I_VSRC_OVERRIDE(st[1]),
        .I_VSRC_SELECT(st[0]),
        .I_HSYNC(hsync),
        .I_VSYNC(vsync),
        .O_SLICER_THRESHOLD(slicer),
        .O_CLAMP_MIDSCALE(clamp),
        .O_SEPARATOR_THRESHOLD(sep),
        .O_HOLDOVER_LEAD(lead),
        .O_HOLDOVER_TRAIL(trail),
        .O_HORIZONTAL_SOURCE_IN_USE(hsrc),
        .O_VERTICAL_SOURCE_IN_USE(vsrc),
        .O_HOLDOVER(hold)
    );
    twowire_master_model m (
        .clk(clk),
        .sda_in(sda),
        .scl(scl),
        .sda_pull(m_pull),
        .res_valid(res_valid),
        .res_data(res_data)
    );
    // ------------------------------
    // checking helpers
    // ------------------------------
    task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic expect8(input string nm, input logic [7:0] v);
        exp_q.push_back('{nm, v});
    endtask
    // status byte worked out from the pin levels
    function automatic logic [7:0] status_exp();
        logic hs;
        logic vs;
        hs = (!st[3] && (st[9] ^ st[5])) ? st[5] : st[2];
        vs = st[1] ? st[0] : st[7];
        return {st[9], hs, st[8], st[7], vs, st[6], st[5], st[4]};
    endfunction
    // oldest note is compared with each result from the master
    always @(posedge clk) begin
        if (res_valid) begin
            if (exp_q.size() == 0) begin
                check8("unexpected result", 8'hFF, res_data);
            end else begin
                check8(exp_q[0].nm, exp_q[0].v, res_data);
                void'(exp_q.pop_front());
            end
        end
    end
    task automatic ctrl_chk();
        check8("slicer", {3'h0, mirror[0][7:3]}, {3'h0, slicer});
        check8("clamp", {5'h00, mirror[0][2:0]}, {5'h00, clamp});
        check8("separator", mirror[1], sep);
        check8("lead", mirror[2], lead);
        check8("trail", mirror[3], trail);
    endtask
    task automatic addr_phase(input logic [1:0] a, input logic rw, input logic ok);
        m.start_cond();
        expect8("address ack", {7'h00, ok});
        m.put_byte({`DEV_ADDR_HIGH, a, rw});
    endtask
    task automatic wr(input logic [7:0] base, input logic [7:0] d[$]);
        logic [7:0] p;
        p = base;
        addr_phase(sa, 1'b0, 1'b1);
        expect8("base ack", {7'h00, base <= `OFS_LAST});
        m.put_byte(base);
        if (base <= `OFS_LAST) begin
            foreach (d[i]) begin
                expect8("data ack", 8'h01);
                m.put_byte(d[i]);
                if (p < `OFS_STATUS) mirror[p - 8'h10] = d[i];
                if (p < `OFS_LAST) p++;
            end
        end
        m.stop_cond();
    endtask
    task automatic rd(input logic [7:0] base, input int n);
        logic [7:0] p;
        p = base;
        addr_phase(sa, 1'b0, 1'b1);
        expect8("base ack", 8'h01);
        m.put_byte(base);
        addr_phase(sa, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            expect8("read data", p == `OFS_STATUS ? status_exp() : mirror[p - 8'h10]);
            m.get_byte(i == n - 1);
            if (p < `OFS_LAST) p++;
        end
        m.stop_cond();
    endtask
    task automatic hs_pulses(input int n);
        repeat (n) begin
            hsync <= 1'b1;
            repeat (10) @(posedge clk);
            hsync <= 1'b0;
            repeat (10) @(posedge clk);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        ctrl_chk();
        rd(8'h10, 7);
        $display("done: reset values");
        for (int i = 0; i < 3; i++) begin
            rnd = 8'($random(seed));
            wr(8'h10, '{i == 0 ? 8'hFF : i == 1 ? 8'h08 : rnd});
            ctrl_chk();
        end
        // separator count above the widest hsync pulse
        rnd = 8'($random(seed));
        wr(8'h10, '{rnd, rnd | 8'h80, 8'h02, 8'h02, 8'hFF, 8'h5A});
        ctrl_chk();
        rd(8'h10, 5);
        $display("done: burst write");
        wr(8'h15, '{8'h11});
        wr(8'h14, '{8'h00});
        rd(8'h13, 2);
        $display("done: base limits");
        for (int k = 0; k < 4; k++) begin
            sa <= 2'(k);
            st <= 10'($random(seed));
            repeat (20) @(posedge clk);
            addr_phase(2'(k + 1), 1'b0, 1'b0);
            m.stop_cond();
            rd(8'h14, 2);
            rnd = status_exp();
            check8("sources", {6'h00, rnd[6], rnd[3]}, {6'h00, hsrc, vsrc});
        end
        $display("done: address select and status");
        vsync <= 1'b1;
        repeat (40) @(posedge clk);
        check8("hold in vsync", 8'h01, {7'h00, hold});
        vsync <= 1'b0;
        repeat (20) @(posedge clk);
        check8("hold trailing", 8'h01, {7'h00, hold});
        hs_pulses(6);
        check8("hold ended", 8'h00, {7'h00, hold});
        // second frame learns six lines; lead of two opens at line four
        vsync <= 1'b1;
        repeat (20) @(posedge clk);
        vsync <= 1'b0;
        hs_pulses(3);
        check8("hold early", 8'h00, {7'h00, hold});
        hs_pulses(1);
        check8("hold lead", 8'h01, {7'h00, hold});
        $display("done: holdover");
        check8("pending notes", 8'h00, 8'(exp_q.size()));
        tally_and_finish();
    end
    // watchdog: about five times the expected run
    initial begin
        #130000;
        fail_count++;
        tally_and_finish();
    end
endmodule
